// [scad_map.vh]
// Constants for the command and address decoder: commands, register map, fields, reset values
`ifndef SCAD_MAP_VH
`define SCAD_MAP_VH

// ****************************************************************
// Pin-level command encodings, {row_strobe_n, column_strobe_n, write_strobe_n}
// ****************************************************************
`define SCAD_PIN_MRS        3'h0
`define SCAD_PIN_REF        3'h1
`define SCAD_PIN_PRE        3'h2
`define SCAD_PIN_ACT        3'h3
`define SCAD_PIN_WR         3'h4
`define SCAD_PIN_RD         3'h5

// ****************************************************************
// Decoded command codes as seen on o_cmd_code
// ****************************************************************
`define SCAD_CMD_NOP        3'h0
`define SCAD_CMD_ACT        3'h1
`define SCAD_CMD_PRE        3'h2
`define SCAD_CMD_RD         3'h3
`define SCAD_CMD_WR         3'h4
`define SCAD_CMD_MRS        3'h5
`define SCAD_CMD_REF        3'h6

// ****************************************************************
// Address bit positions
// ****************************************************************
`define SCAD_AUTO_CLOSE_POS 10
`define SCAD_BURST_CUT_POS  12
`define SCAD_COL_MSB        9

// ****************************************************************
// Burst lengths in transfers
// ****************************************************************
`define SCAD_BURST_FULL     4'h8
`define SCAD_BURST_CUT      4'h4

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SCAD_REG_CTRL       4'h0
`define SCAD_REG_STATUS     4'h4
`define SCAD_REG_LASTCMD    4'h8
`define SCAD_REG_MODE       4'hC

// ****************************************************************
// Register fields and reset values
// ****************************************************************
`define SCAD_CTRL_DEC_EN    0
`define SCAD_CTRL_RST       32'h0000_0001
`define SCAD_ST_OPEN_LSB    0
`define SCAD_ST_PD_POS      8
`define SCAD_ST_SR_POS      9
`define SCAD_ST_RUN_POS     10
`define SCAD_ST_BURST_POS   11

`endif

// [scad_sync.v]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module scad_sync #(
  parameter          W       = 1,
  parameter [W-1:0]  RST_VAL = {W{1'b0}}
)(
  // Clock, reset, enable
  input  wire         i_clk_sys,
  input  wire         i_srst,
  input  wire         i_ce,
  // Asynchronous inputs and filtered result
  input  wire [W-1:0] i_d,
  output reg  [W-1:0] o_q
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;

  // Stage1 feeds stage2 only; the filter looks at stages 2 and 3
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      o_q    <= RST_VAL;
    end
    else if (i_ce)
    begin
      stage1 <= i_d;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        o_q <= stage3;
    end
  end

endmodule // scad_sync

// [scad_decode.v]
// Command and address decoder of a DDR memory device, sampled on the system clock
`timescale 1ns/1ps
`include "scad_map.vh"

module scad_decode #(
  parameter BANKS = 8,
  parameter BA_W  = 3,
  parameter A_W   = 13
)(
  // Clock, reset, enable
  input  wire              i_clk_sys,
  input  wire              i_srst,
  input  wire              i_ce,
  // Memory link pins
  input  wire              i_ck,
  input  wire              i_ck_n,
  input  wire              i_clock_gate,
  input  wire              i_chip_select_n,
  input  wire              i_row_strobe_n,
  input  wire              i_column_strobe_n,
  input  wire              i_write_strobe_n,
  input  wire [BA_W-1:0]   i_bank_select,
  input  wire [A_W-1:0]    i_addr,
  // Register port
  input  wire [3:0]        i_reg_addr,
  input  wire [31:0]       i_reg_wdata,
  input  wire              i_reg_wr,
  input  wire              i_reg_rd,
  output reg  [31:0]       o_reg_rdata,
  // Decoded command
  output reg               o_cmd_pulse,
  output reg  [2:0]        o_cmd_code,
  output reg  [BA_W-1:0]   o_cmd_bank,
  output reg  [A_W-1:0]    o_row_addr,
  output reg  [`SCAD_COL_MSB:0] o_col_addr,
  output reg               o_auto_close,
  output reg               o_full_burst,
  output reg               o_close_all,
  output reg  [A_W+BA_W-1:0] o_mode_opcode,
  // Device state
  output reg  [BANKS-1:0]  o_bank_open,
  output reg               o_clk_run,
  output reg               o_power_down,
  output reg               o_self_refresh,
  // Burst transfer timing
  output reg               o_beat,
  output reg               o_beat_read,
  output reg  [BA_W-1:0]   o_beat_bank,
  output reg  [`SCAD_COL_MSB:0] o_beat_col
);

  // ****************************************************************
  // Command decode function
  // ****************************************************************
  function [2:0] cmd_of;
    input       cs_n;
    input [2:0] strobes;
    begin
      if (cs_n)
        cmd_of = `SCAD_CMD_NOP;
      else
        case (strobes)
          `SCAD_PIN_ACT: cmd_of = `SCAD_CMD_ACT;
          `SCAD_PIN_PRE: cmd_of = `SCAD_CMD_PRE;
          `SCAD_PIN_RD:  cmd_of = `SCAD_CMD_RD;
          `SCAD_PIN_WR:  cmd_of = `SCAD_CMD_WR;
          `SCAD_PIN_MRS: cmd_of = `SCAD_CMD_MRS;
          `SCAD_PIN_REF: cmd_of = `SCAD_CMD_REF;
          default:       cmd_of = `SCAD_CMD_NOP;
        endcase
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam PIN_W = 1 + 4 + BA_W + A_W;

  wire [1:0]       ck_pair;
  wire [PIN_W-1:0] pins;

  // Clock pair and command pins share latency so they stay aligned
  scad_sync #(.W(2), .RST_VAL(2'h1)) u_ck_sync (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_ce      (i_ce),
    .i_d       ({i_ck, i_ck_n}),
    .o_q       (ck_pair)
  );

  scad_sync #(.W(PIN_W), .RST_VAL({1'b0, 4'hF, {(BA_W + A_W){1'b0}}})) u_pin_sync (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_ce      (i_ce),
    .i_d       ({i_clock_gate, i_chip_select_n, i_row_strobe_n, i_column_strobe_n,
                 i_write_strobe_n, i_bank_select, i_addr}),
    .o_q       (pins)
  );

  wire            s_gate   = pins[PIN_W-1];
  wire            s_cs_n   = pins[PIN_W-2];
  wire [2:0]      s_strobe = pins[PIN_W-3:PIN_W-5];
  wire [BA_W-1:0] s_bank   = pins[BA_W+A_W-1:A_W];
  wire [A_W-1:0]  s_addr   = pins[A_W-1:0];

  // ****************************************************************
  // Crossing detection
  // ****************************************************************
  reg  ck_hi;
  wire now_hi  = ck_pair[1] & ~ck_pair[0];
  wire now_lo  = ~ck_pair[1] & ck_pair[0];
  wire rise    = now_hi & ~ck_hi;
  wire fall    = now_lo & ck_hi;

  always @(posedge i_clk_sys)
  begin
    if (i_srst)
      ck_hi <= 1'b0;
    else if (i_ce)
    begin
      if (rise)
        ck_hi <= 1'b1;
      else if (fall)
        ck_hi <= 1'b0;
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  reg        burst_act;
  reg [31:0] ctrl;
  wire       dec_en = ctrl[`SCAD_CTRL_DEC_EN];

  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      ctrl        <= `SCAD_CTRL_RST;
      o_reg_rdata <= 32'h0000_0000;
    end
    else if (i_ce)
    begin
      if (i_reg_wr && i_reg_addr == `SCAD_REG_CTRL)
        ctrl <= {31'h0000_0000, i_reg_wdata[`SCAD_CTRL_DEC_EN]};
      if (!i_reg_rd)
        o_reg_rdata <= 32'h0000_0000;
      else if (i_reg_addr == `SCAD_REG_CTRL)
        o_reg_rdata <= ctrl;
      else if (i_reg_addr == `SCAD_REG_STATUS)
        o_reg_rdata <= {20'h0_0000, burst_act, o_clk_run, o_self_refresh, o_power_down,
                        {(8-BANKS){1'b0}}, o_bank_open};
      else if (i_reg_addr == `SCAD_REG_LASTCMD)
        o_reg_rdata <= {o_cmd_code, o_cmd_bank, {(26-A_W){1'b0}}, o_row_addr};
      else if (i_reg_addr == `SCAD_REG_MODE)
        o_reg_rdata <= {{(32-A_W-BA_W){1'b0}}, o_mode_opcode};
      else
        o_reg_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Command sampling and bank state
  // ****************************************************************
  wire [2:0]       raw_cmd  = cmd_of(s_cs_n, s_strobe);
  // A command counts only while the internal clock ran and keeps running
  wire             cmd_live = rise & o_clk_run & s_gate & dec_en;
  wire [2:0]       cmd      = cmd_live ? raw_cmd : `SCAD_CMD_NOP;
  wire             all_idle = ~|o_bank_open;
  wire [BANKS-1:0] bank_bit = {{(BANKS-1){1'b0}}, 1'b1} << s_bank;

  reg [3:0]        beat_cnt;
  reg [3:0]        beat_len;
  reg [BA_W-1:0]   burst_bank;
  reg [`SCAD_COL_MSB:0] burst_col;
  reg              burst_close;
  reg              burst_read;
  reg [BANKS-1:0]  pre_pend;
  reg [BANKS-1:0]  next_open;
  reg [BANKS-1:0]  next_pend;
  // Advances on both crossings, and only while the internal clock runs
  wire             beat_step = burst_act & o_clk_run & (rise | fall);
  wire             burst_end = beat_step & (beat_cnt == beat_len - 4'h1);

  always @*
  begin
    next_open = o_bank_open;
    next_pend = pre_pend;
    if (rise)
    begin
      // Precharge finishes one link cycle after it was issued
      next_open = next_open & ~pre_pend;
      next_pend = {BANKS{1'b0}};
    end
    if (cmd == `SCAD_CMD_ACT)
      next_open = next_open | bank_bit;
    if (cmd == `SCAD_CMD_PRE)
      next_pend = s_addr[`SCAD_AUTO_CLOSE_POS] ? {BANKS{1'b1}} : bank_bit;
    if (burst_end && burst_close)
      next_pend = next_pend | ({{(BANKS-1){1'b0}}, 1'b1} << burst_bank);
  end

  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_cmd_pulse    <= 1'b0;
      o_cmd_code     <= `SCAD_CMD_NOP;
      o_cmd_bank     <= {BA_W{1'b0}};
      o_row_addr     <= {A_W{1'b0}};
      o_col_addr     <= {(`SCAD_COL_MSB+1){1'b0}};
      o_auto_close   <= 1'b0;
      o_full_burst   <= 1'b0;
      o_close_all    <= 1'b0;
      o_mode_opcode  <= {(A_W+BA_W){1'b0}};
      o_bank_open    <= {BANKS{1'b0}};
      pre_pend       <= {BANKS{1'b0}};
      o_clk_run      <= 1'b0;
      o_power_down   <= 1'b0;
      o_self_refresh <= 1'b0;
    end
    else if (i_ce)
    begin
      o_cmd_pulse <= 1'b0;
      o_bank_open <= next_open;
      pre_pend    <= next_pend;
      if (rise)
      begin
        o_clk_run <= s_gate;
        if (!s_gate && o_clk_run && all_idle)
        begin
          // Refresh with the gate dropping selects self-refresh
          if (raw_cmd == `SCAD_CMD_REF)
            o_self_refresh <= 1'b1;
          else
            o_power_down <= 1'b1;
        end
        else if (s_gate)
        begin
          o_power_down   <= 1'b0;
          o_self_refresh <= 1'b0;
        end
      end
      if (cmd != `SCAD_CMD_NOP)
      begin
        o_cmd_pulse <= 1'b1;
        o_cmd_code  <= cmd;
        o_cmd_bank  <= s_bank;
        o_close_all <= (cmd == `SCAD_CMD_PRE) & s_addr[`SCAD_AUTO_CLOSE_POS];
      end
      if (cmd == `SCAD_CMD_ACT)
        o_row_addr <= s_addr;
      if (cmd == `SCAD_CMD_RD || cmd == `SCAD_CMD_WR)
      begin
        o_col_addr   <= s_addr[`SCAD_COL_MSB:0];
        o_auto_close <= s_addr[`SCAD_AUTO_CLOSE_POS];
        o_full_burst <= s_addr[`SCAD_BURST_CUT_POS];
      end
      if (cmd == `SCAD_CMD_MRS)
        o_mode_opcode <= {s_bank, s_addr};
    end
  end

  // ****************************************************************
  // Burst transfer counter
  // ****************************************************************
  wire rw_cmd    = (cmd == `SCAD_CMD_RD) | (cmd == `SCAD_CMD_WR);

  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      burst_act   <= 1'b0;
      beat_cnt    <= 4'h0;
      beat_len    <= `SCAD_BURST_FULL;
      burst_bank  <= {BA_W{1'b0}};
      burst_col   <= {(`SCAD_COL_MSB+1){1'b0}};
      burst_close <= 1'b0;
      burst_read  <= 1'b0;
      o_beat      <= 1'b0;
      o_beat_read <= 1'b0;
      o_beat_bank <= {BA_W{1'b0}};
      o_beat_col  <= {(`SCAD_COL_MSB+1){1'b0}};
    end
    else if (i_ce)
    begin
      o_beat <= beat_step;
      if (beat_step)
      begin
        o_beat_read <= burst_read;
        o_beat_bank <= burst_bank;
        o_beat_col  <= burst_col + {{(`SCAD_COL_MSB-2){1'b0}}, beat_cnt[2:0]};
        beat_cnt    <= beat_cnt + 4'h1;
      end
      // A new column command cuts short any burst still running
      if (rw_cmd)
      begin
        burst_act   <= 1'b1;
        beat_cnt    <= 4'h0;
        beat_len    <= s_addr[`SCAD_BURST_CUT_POS] ? `SCAD_BURST_FULL : `SCAD_BURST_CUT;
        burst_bank  <= s_bank;
        burst_col   <= s_addr[`SCAD_COL_MSB:0];
        burst_close <= s_addr[`SCAD_AUTO_CLOSE_POS];
        burst_read  <= (cmd == `SCAD_CMD_RD);
      end
      else if (burst_end)
        burst_act <= 1'b0;
    end
  end

endmodule // scad_decode

// [scad_decode_chk.sv]
// Assertion checker for the command and address decoder ports
`timescale 1ns/1ps
`include "scad_map.vh"

module scad_decode_chk #(
  parameter BANKS = 8,
  parameter BA_W  = 3,
  parameter A_W   = 13
)(
  // Clock and reset
  input wire             i_clk_sys,
  input wire             i_srst,
  // Register port
  input wire             i_ce,
  input wire [3:0]       i_reg_addr,
  input wire             i_reg_rd,
  input wire [31:0]      o_reg_rdata,
  // Decoded command and state
  input wire             o_cmd_pulse,
  input wire [2:0]       o_cmd_code,
  input wire [BA_W-1:0]  o_cmd_bank,
  input wire             o_close_all,
  input wire [BANKS-1:0] o_bank_open,
  input wire             o_clk_run,
  input wire             o_power_down,
  input wire             o_self_refresh,
  input wire             o_beat
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  cmd_single_a: assert property (o_cmd_pulse |=> !o_cmd_pulse)
    else $error("command pulse longer than one cycle");
  pulse_real_a: assert property (o_cmd_pulse |-> o_cmd_code != `SCAD_CMD_NOP)
    else $error("pulse without a command");
  act_opens_a: assert property (o_cmd_pulse && o_cmd_code == `SCAD_CMD_ACT |-> o_bank_open[o_cmd_bank])
    else $error("activate left its bank closed");
  close_all_a: assert property (o_close_all |-> o_cmd_code == `SCAD_CMD_PRE)
    else $error("close-all flag without precharge");
  pulse_run_a: assert property (o_cmd_pulse |-> o_clk_run)
    else $error("command decoded while clock stopped");
  beat_run_a: assert property (o_beat |-> $past(o_clk_run))
    else $error("burst moved while clock stopped");
  pd_idle_a: assert property ($rose(o_power_down) |-> o_bank_open == 0)
    else $error("power-down with an open bank");
  pd_mode_a: assert property (o_power_down |-> !o_clk_run && !o_self_refresh)
    else $error("power-down with clock running");
  status_read_a: assert property (i_ce && i_reg_rd && i_reg_addr == `SCAD_REG_STATUS
    |=> o_reg_rdata[7:0] == $past(o_bank_open))
    else $error("status read shows wrong banks");
endmodule // scad_decode_chk

bind scad_decode scad_decode_chk #(.BANKS(BANKS), .BA_W(BA_W), .A_W(A_W)) u_chk (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ce(i_ce), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_cmd_pulse(o_cmd_pulse), .o_cmd_code(o_cmd_code), .o_cmd_bank(o_cmd_bank),
  .o_close_all(o_close_all), .o_bank_open(o_bank_open), .o_clk_run(o_clk_run),
  .o_power_down(o_power_down), .o_self_refresh(o_self_refresh), .o_beat(o_beat));

// [scad_ctl_model.sv]
// Behavioural memory controller driving the link pins
`timescale 1ns/1ps

module scad_ctl_model (
  // Link clock pair
  output reg        o_ck,
  output reg        o_ck_n,
  // Command and address pins
  output reg        o_gate,
  output reg        o_cs_n,
  output reg [2:0]  o_strobe_n,
  output reg [2:0]  o_bank,
  output reg [12:0] o_addr
);
  reg        pend;
  reg        next_gate;
  reg        next_cs_n;
  reg [2:0]  next_strobe;
  reg [2:0]  next_bank;
  reg [12:0] next_addr;

  initial
  begin
    {o_ck, o_ck_n, o_gate, o_cs_n, o_strobe_n, o_bank, o_addr} = 23'h2f_0000;
    {next_gate, pend} = 2'h0;
    // Odd offset keeps the link phase unrelated to the system clock
    #37;
    forever
    begin
      #400 o_ck = ~o_ck;
      o_ck_n = ~o_ck;
    end
  end

  // Pins change at the fall, half a period before the capturing crossing
  always @(negedge o_ck)
  begin
    o_gate <= next_gate;
    if (pend)
    begin
      {o_cs_n, o_strobe_n, o_bank, o_addr} <= {next_cs_n, next_strobe, next_bank, next_addr};
      pend <= 1'b0;
    end
    else
    begin
      // Deselected lines keep moving so a stale command cannot look valid
      o_cs_n <= 1'b1;
      o_strobe_n <= ~o_strobe_n;
      o_bank <= ~o_bank;
      o_addr <= ~o_addr;
    end
  end

  task issue(input g, input cs, input [2:0] s, input [2:0] b, input [12:0] a);
  begin
    {next_gate, next_cs_n, next_strobe, next_bank, next_addr} = {g, cs, s, b, a};
    pend = 1'b1;
    wait (!pend);
    @(posedge o_ck);
  end
  endtask
endmodule // scad_ctl_model

// [scad_decode_tb.sv]
// Self-checking testbench for the command and address decoder
`timescale 1ns/1ps
`include "scad_map.vh"

module scad_decode_tb;
  reg          clk, srst, wr, rd, rd_d, g, run, pd, sr, beat, bread, pulse, ac, fb, ca, lastrd;
  reg  [3:0]   ra;
  reg  [31:0]  wd;
  wire [31:0]  rdata;
  wire         ck, ckn, lg, csn;
  wire [2:0]   sn, ba, code, cbank, bbank;
  wire [12:0]  ad, row;
  wire [9:0]   col, bcol;
  wire [15:0]  mop;
  wire [7:0]   bopen;
  reg  [15:0]  f;
  reg  [12:0]  r;
  reg  [2:0]   lastbk;
  reg  [9:0]   c, lastcol;
  logic [31:0] cq[$], rq[$];
  integer      n_fail, n_compared, nbeat, cyc, i;

  scad_ctl_model u_ctl (.o_ck(ck), .o_ck_n(ckn), .o_gate(lg), .o_cs_n(csn), .o_strobe_n(sn), .o_bank(ba),
    .o_addr(ad));
  scad_decode dut (.i_clk_sys(clk), .i_srst(srst), .i_ce(1'b1), .i_ck(ck), .i_ck_n(ckn), .i_clock_gate(lg),
    .i_chip_select_n(csn), .i_row_strobe_n(sn[2]), .i_column_strobe_n(sn[1]), .i_write_strobe_n(sn[0]),
    .i_bank_select(ba), .i_addr(ad), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_cmd_pulse(pulse), .o_cmd_code(code), .o_cmd_bank(cbank), .o_row_addr(row),
    .o_col_addr(col), .o_auto_close(ac), .o_full_burst(fb), .o_close_all(ca), .o_mode_opcode(mop),
    .o_bank_open(bopen), .o_clk_run(run), .o_power_down(pd), .o_self_refresh(sr), .o_beat(beat),
    .o_beat_read(bread), .o_beat_bank(bbank), .o_beat_col(bcol));

  task chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  task end_of_test;
  begin
    chk(cq.size() + rq.size(), 0);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  // Read expectations go to the queue, the monitor compares a cycle later
  task rw(input w, input [3:0] a, input [31:0] d);
  begin
    @(posedge clk);
    {wr, rd, ra, wd} <= {w, !w, a, d};
    if (!w)
      rq.push_back(d);
    @(posedge clk);
    {wr, rd} <= 2'h0;
  end
  endtask

  task cmd(input cs, input [2:0] s, input [2:0] b, input [12:0] a);
    u_ctl.issue(g, cs, s, b, a);
  endtask

  task nop(input integer n);
    repeat (n) cmd(1'b1, 3'h7, 3'h0, 13'h0);
  endtask

  task ex(input [2:0] cd, input [2:0] b, input [15:0] fd);
    cq.push_back({10'h0, cd, b, fd});
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (rd_d)
      chk(rdata, rq.pop_front());
    rd_d <= rd;
    if (beat)
      {nbeat, lastbk, lastcol, lastrd} = {nbeat + 1, bbank, bcol, bread};
    if (pulse)
    begin
      case (code)
        `SCAD_CMD_ACT: f = {3'h0, row};
        `SCAD_CMD_RD, `SCAD_CMD_WR: f = {4'h0, ac, fb, col};
        `SCAD_CMD_PRE: f = {15'h0, ca};
        default: f = mop;
      endcase
      chk({10'h0, code, cbank, f}, (cq.size() > 0) ? cq.pop_front() : 32'h0);
    end
    if (cyc == 6000)
    begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end

  initial
  begin
    {srst, wr, rd, rd_d, g, ra, wd} = {5'h10, 4'h0, 32'h0};
    {n_fail, n_compared, nbeat, cyc} = 0;
    void'($urandom(56));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({code, bopen}, {`SCAD_CMD_NOP, 8'h0});
    rw(0, `SCAD_REG_CTRL, `SCAD_CTRL_RST);
    rw(0, 4'h2, 32'h0);
    rw(1, `SCAD_REG_CTRL, 32'h0);
    g = 1'b1;
    nop(2);
    cmd(0, `SCAD_PIN_ACT, 3'h1, 13'h0);
    // Let the disabled command pass the synchronisers before enabling
    nop(1);
    rw(1, `SCAD_REG_CTRL, 32'h1);
    cmd(1, `SCAD_PIN_ACT, 3'h1, 13'h0);
    for (i = 0; i < 8; i++)
    begin
      r = 13'($urandom);
      ex(`SCAD_CMD_ACT, i[2:0], {3'h0, r});
      cmd(0, `SCAD_PIN_ACT, i[2:0], r);
    end
    nop(1);
    rw(0, `SCAD_REG_STATUS, 32'h0000_04ff);
    c = {7'($urandom), 3'h0};
    nbeat = 0;
    ex(`SCAD_CMD_RD, 3'h2, {6'h01, c});
    cmd(0, `SCAD_PIN_RD, 3'h2, {3'h4, c});
    nop(5);
    chk({nbeat[7:0], lastbk, lastcol, lastrd, bopen}, {8'h8, 3'h2, c + 10'h7, 1'b1, 8'hff});
    nbeat = 0;
    ex(`SCAD_CMD_WR, 3'h3, {6'h02, c});
    cmd(0, `SCAD_PIN_WR, 3'h3, {3'h1, c});
    nop(4);
    chk({nbeat[7:0], lastrd, bopen}, {8'h4, 1'b0, 8'hf7});
    ex(`SCAD_CMD_PRE, 3'h0, 16'h0);
    cmd(0, `SCAD_PIN_PRE, 3'h0, 13'h0);
    nop(2);
    chk(bopen, 8'hf6);
    ex(`SCAD_CMD_PRE, 3'h5, 16'h1);
    cmd(0, `SCAD_PIN_PRE, 3'h5, 13'h0400);
    nop(2);
    chk(bopen, 8'h0);
    r = 13'($urandom);
    ex(`SCAD_CMD_MRS, 3'h5, {3'h5, r});
    cmd(0, `SCAD_PIN_MRS, 3'h5, r);
    ex(`SCAD_CMD_REF, 3'h0, {3'h5, r});
    cmd(0, `SCAD_PIN_REF, 3'h0, 13'h0);
    // Gate drops here with every bank idle
    g = 1'b0;
    nop(2);
    cmd(0, `SCAD_PIN_ACT, 3'h4, 13'h0);
    chk({pd, run, bopen}, {2'h2, 8'h0});
    g = 1'b1;
    nop(2);
    chk({pd, run}, 2'h1);
    g = 1'b0;
    cmd(0, `SCAD_PIN_REF, 3'h0, 13'h0);
    nop(1);
    chk({sr, pd}, 2'h2);
    g = 1'b1;
    nop(2);
    ex(`SCAD_CMD_ACT, 3'h1, 16'h0);
    cmd(0, `SCAD_PIN_ACT, 3'h1, 13'h0);
    nbeat = 0;
    g = 1'b0;
    cmd(0, `SCAD_PIN_RD, 3'h1, 13'h1000);
    nop(3);
    chk({nbeat[7:0], bopen, pd}, {8'h0, 8'h02, 1'b0});
    g = 1'b1;
    nop(2);
    end_of_test;
  end
endmodule // scad_decode_tb
